// >>> hdl/gpio_ab_pkg.sv
package gpio_ab_pkg;
    localparam int PORT_WIDTH = 8;
    localparam int ADDR_WIDTH = 4;
    localparam int CHAN_WIDTH = 5;
    // byte addresses: data and direction word-aligned, pullup and key enable not
    localparam logic [ADDR_WIDTH-1:0] ADDR_PORT_A_DATA = 4'h0;
    localparam logic [ADDR_WIDTH-1:0] ADDR_PORT_B_DATA = 4'h4;
    localparam logic [ADDR_WIDTH-1:0] ADDR_PORT_A_DIR = 4'h8;
    localparam logic [ADDR_WIDTH-1:0] ADDR_PORT_B_DIR = 4'hC;
    localparam logic [ADDR_WIDTH-1:0] ADDR_PORT_A_PULLUP = 4'h1;
    localparam logic [ADDR_WIDTH-1:0] ADDR_KEY_ENABLE = 4'h5;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] PULLUP_RESET = 8'h00;
    localparam logic [7:0] KEY_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    // channel codes at or above this select no port B pin
    localparam logic [CHAN_WIDTH-1:0] CHAN_LIMIT = 5'h08;
endpackage : gpio_ab_pkg

// >>> hdl/gpio_ports_a_b.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_a_b
    import gpio_ab_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [WIDTH-1:0] portAIn,
    output logic [WIDTH-1:0] portAOut,
    output logic [WIDTH-1:0] portAOe,
    output logic [WIDTH-1:0] portAPullup,
    input wire logic [WIDTH-1:0] portBIn,
    output logic [WIDTH-1:0] portBOut,
    output logic [WIDTH-1:0] portBOe,
    input wire logic [CHAN_WIDTH-1:0] analog_channel_select,
    output logic [WIDTH-1:0] key_inputs,
    output logic [WIDTH-1:0] key_pin_enables
);

    ////////////////////////////////////////////////////////////////
    logic [WIDTH-1:0] port_a_data_latch, next_port_a_data_latch;
    logic [WIDTH-1:0] port_b_data_latch, next_port_b_data_latch;
    logic [WIDTH-1:0] port_a_direction, next_port_a_direction;
    logic [WIDTH-1:0] port_b_direction, next_port_b_direction;
    logic [WIDTH-1:0] port_a_pullup_enable, next_port_a_pullup_enable;
    logic [WIDTH-1:0] keyEnable, next_keyEnable;
    logic [WIDTH-1:0] pinAMeta, pinASync, pinBMeta, pinBSync;
    logic [CHAN_WIDTH-1:0] chanMeta, chanSync;
    logic [WIDTH-1:0] analogMask;
    logic [31:0] next_wb_dat_o;
    logic next_wb_ack_o;
    logic busWrite, busRead;
    // enough channel bits to name one port B pin
    localparam int CHAN_PIN_BITS = $clog2(WIDTH);

    ////////////////////////////////////////////////////////////////
    // pins and channel select come from outside: two flops first
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pinAMeta <= '0;
            pinASync <= '0;
            pinBMeta <= '0;
            pinBSync <= '0;
            chanMeta <= CHAN_LIMIT;
            chanSync <= CHAN_LIMIT;
        end else begin
            pinAMeta <= portAIn;
            pinASync <= pinAMeta;
            pinBMeta <= portBIn;
            pinBSync <= pinBMeta;
            chanMeta <= analog_channel_select;
            chanSync <= chanMeta;
        end
    end

    always_comb begin
        analogMask = '0;
        if (chanSync < CHAN_LIMIT) begin
            analogMask[chanSync[CHAN_PIN_BITS-1:0]] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // bus: ack one cycle after request, dropped the cycle after
    assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign busRead = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

    always_comb begin
        next_port_a_data_latch = port_a_data_latch;
        next_port_b_data_latch = port_b_data_latch;
        next_port_a_direction = port_a_direction;
        next_port_b_direction = port_b_direction;
        next_port_a_pullup_enable = port_a_pullup_enable;
        next_keyEnable = keyEnable;
        next_wb_ack_o = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_wb_dat_o = UNMAPPED_READ;
        if (busWrite) begin
            unique case (wb_adr_i)
                ADDR_PORT_A_DATA: next_port_a_data_latch = wb_dat_i[WIDTH-1:0];
                ADDR_PORT_B_DATA: next_port_b_data_latch = wb_dat_i[WIDTH-1:0];
                ADDR_PORT_A_DIR: next_port_a_direction = wb_dat_i[WIDTH-1:0];
                ADDR_PORT_B_DIR: next_port_b_direction = wb_dat_i[WIDTH-1:0];
                ADDR_PORT_A_PULLUP: next_port_a_pullup_enable = wb_dat_i[WIDTH-1:0];
                ADDR_KEY_ENABLE: next_keyEnable = wb_dat_i[WIDTH-1:0];
                default: ;
            endcase
        end
        if (busRead) begin
            unique case (wb_adr_i)
                // mix latch and pin per direction bit
                ADDR_PORT_A_DATA: next_wb_dat_o[WIDTH-1:0] =
                    (port_a_direction & port_a_data_latch) | (~port_a_direction & pinASync);
                ADDR_PORT_B_DATA: next_wb_dat_o[WIDTH-1:0] =
                    (port_b_direction & port_b_data_latch) | (~port_b_direction & pinBSync);
                ADDR_PORT_A_DIR: next_wb_dat_o[WIDTH-1:0] = port_a_direction;
                ADDR_PORT_B_DIR: next_wb_dat_o[WIDTH-1:0] = port_b_direction;
                ADDR_PORT_A_PULLUP: next_wb_dat_o[WIDTH-1:0] = port_a_pullup_enable;
                ADDR_KEY_ENABLE: next_wb_dat_o[WIDTH-1:0] = keyEnable;
                default: next_wb_dat_o = UNMAPPED_READ;
            endcase
        end
    end

    // latches have no reset: their contents survive a reset
    always_ff @(posedge ref_clk) begin
        port_a_data_latch <= next_port_a_data_latch;
        port_b_data_latch <= next_port_b_data_latch;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            port_a_direction <= DIR_RESET;
            port_b_direction <= DIR_RESET;
            port_a_pullup_enable <= PULLUP_RESET;
            keyEnable <= KEY_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= UNMAPPED_READ;
        end else begin
            port_a_direction <= next_port_a_direction;
            port_b_direction <= next_port_b_direction;
            port_a_pullup_enable <= next_port_a_pullup_enable;
            keyEnable <= next_keyEnable;
            wb_ack_o <= next_wb_ack_o;
            wb_dat_o <= next_wb_dat_o;
        end
    end

    ////////////////////////////////////////////////////////////////
    // pin outputs registered; latch is X until first write, so the
    // drive data is masked by the enable to keep outputs defined
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            portAOe <= '0;
            portAOut <= '0;
            portAPullup <= '0;
            portBOe <= '0;
            portBOut <= '0;
            key_inputs <= '0;
            key_pin_enables <= '0;
        end else begin
            portAOe <= port_a_direction;
            portAOut <= port_a_direction & port_a_data_latch;
            portAPullup <= port_a_pullup_enable & ~port_a_direction;
            portBOe <= port_b_direction & ~analogMask;
            portBOut <= port_b_direction & ~analogMask & port_b_data_latch;
            key_inputs <= keyEnable & pinASync;
            key_pin_enables <= keyEnable;
        end
    end

    ////////////////////////////////////////////////////////////////
    // latches start unknown, so checks that read them only look where direction masks them
    // or after a write has loaded them
    property p_dir_a_reset;
        @(posedge ref_clk) $rose(nrst) |-> portAOe == ZERO_BYTE;
    endproperty
    a_dir_a_reset: assert property (p_dir_a_reset)
        else $error("port A enables not clear after reset");

    property p_dir_b_reset;
        @(posedge ref_clk) $rose(nrst) |-> portBOe == ZERO_BYTE;
    endproperty
    a_dir_b_reset: assert property (p_dir_b_reset)
        else $error("port B enables not clear after reset");

    property p_pullup_reset;
        @(posedge ref_clk) $rose(nrst) |-> portAPullup == ZERO_BYTE;
    endproperty
    a_pullup_reset: assert property (p_pullup_reset)
        else $error("port A pullups not clear after reset");

    property p_oe_follows;
        @(posedge ref_clk) disable iff (!nrst) ##1 portAOe == $past(port_a_direction);
    endproperty
    a_oe_follows: assert property (p_oe_follows)
        else $error("port A enable not following direction");

    property p_out_a;
        @(posedge ref_clk) disable iff (!nrst)
        ##1 portAOut == ($past(port_a_direction) & $past(port_a_data_latch));
    endproperty
    a_out_a: assert property (p_out_a)
        else $error("port A drive data wrong");

    property p_pullup_off;
        @(posedge ref_clk) disable iff (!nrst) (portAPullup & portAOe) == ZERO_BYTE;
    endproperty
    a_pullup_off: assert property (p_pullup_off)
        else $error("pullup on while output");

    property p_pullup_on;
        @(posedge ref_clk) disable iff (!nrst)
        ##1 portAPullup == ($past(port_a_pullup_enable) & ~$past(port_a_direction));
    endproperty
    a_pullup_on: assert property (p_pullup_on)
        else $error("pullup not following enable");

    property p_dir_a_write;
        @(posedge ref_clk) disable iff (!nrst)
        busWrite && wb_adr_i == ADDR_PORT_A_DIR |=>
            port_a_direction == $past(wb_dat_i[WIDTH-1:0]);
    endproperty
    a_dir_a_write: assert property (p_dir_a_write)
        else $error("port A direction not written");

    property p_read_a;
        @(posedge ref_clk) disable iff (!nrst)
        busRead && wb_adr_i == ADDR_PORT_A_DATA |=> wb_ack_o && wb_dat_o[WIDTH-1:0] ==
            (($past(port_a_direction) & $past(port_a_data_latch))
            | (~$past(port_a_direction) & $past(pinASync)));
    endproperty
    a_read_a: assert property (p_read_a)
        else $error("port A read mismatch");

    property p_write_a;
        @(posedge ref_clk) disable iff (!nrst)
        busWrite && wb_adr_i == ADDR_PORT_A_DATA |=>
            port_a_data_latch == $past(wb_dat_i[WIDTH-1:0]);
    endproperty
    a_write_a: assert property (p_write_a)
        else $error("port A latch not written");

    property p_write_b;
        @(posedge ref_clk) disable iff (!nrst)
        busWrite && wb_adr_i == ADDR_PORT_B_DATA |=>
            port_b_data_latch == $past(wb_dat_i[WIDTH-1:0]);
    endproperty
    a_write_b: assert property (p_write_b)
        else $error("port B latch not written");

    property p_dir_b_write;
        @(posedge ref_clk) disable iff (!nrst)
        busWrite && wb_adr_i == ADDR_PORT_B_DIR |=>
            port_b_direction == $past(wb_dat_i[WIDTH-1:0]);
    endproperty
    a_dir_b_write: assert property (p_dir_b_write)
        else $error("port B direction not written");

    property p_read_b;
        @(posedge ref_clk) disable iff (!nrst)
        busRead && wb_adr_i == ADDR_PORT_B_DATA |=> wb_ack_o && wb_dat_o[WIDTH-1:0] ==
            (($past(port_b_direction) & $past(port_b_data_latch))
            | (~$past(port_b_direction) & $past(pinBSync)));
    endproperty
    a_read_b: assert property (p_read_b)
        else $error("port B read mismatch");

    property p_oe_b;
        @(posedge ref_clk) disable iff (!nrst)
        ##1 portBOe == ($past(port_b_direction) & ~$past(analogMask));
    endproperty
    a_oe_b: assert property (p_oe_b)
        else $error("port B enable wrong");

    property p_analog_input;
        @(posedge ref_clk) disable iff (!nrst) ##1 ($past(analogMask) & portBOe) == ZERO_BYTE;
    endproperty
    a_analog_input: assert property (p_analog_input)
        else $error("analog pin driven");

    property p_out_b;
        @(posedge ref_clk) disable iff (!nrst)
        ##1 portBOut == ($past(port_b_direction) & ~$past(analogMask) & $past(port_b_data_latch));
    endproperty
    a_out_b: assert property (p_out_b)
        else $error("port B drive data wrong");

    property p_key;
        @(posedge ref_clk) disable iff (!nrst) (key_inputs & ~key_pin_enables) == ZERO_BYTE;
    endproperty
    a_key: assert property (p_key)
        else $error("key input passed while disabled");

    property p_key_pass;
        @(posedge ref_clk) disable iff (!nrst)
        ##1 key_inputs == ($past(keyEnable) & $past(pinASync));
    endproperty
    a_key_pass: assert property (p_key_pass)
        else $error("key input not following pin");

    property p_ack_req;
        @(posedge ref_clk) disable iff (!nrst) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_req: assert property (p_ack_req)
        else $error("request not acknowledged");

    property p_ack_pulse;
        @(posedge ref_clk) disable iff (!nrst) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");

    property p_dat_idle;
        @(posedge ref_clk) disable iff (!nrst) !busRead |=> wb_dat_o == UNMAPPED_READ;
    endproperty
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data not cleared");

endmodule : gpio_ports_a_b
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin nChecks++; if ((got) !== (exp)) begin nMismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb
    import gpio_ab_pkg::*;
;
    logic ref_clk, nrst, cyc, stb, we, ack;
    logic [ADDR_WIDTH-1:0] adr;
    logic [3:0] sel;
    logic [31:0] datI, datO;
    logic [7:0] aIn, aOut, aOe, aPu, bIn, bOut, bOe, keyIn, keyEn, q;
    logic [CHAN_WIDTH-1:0] chan;
    int nMismatch = 0;
    int nChecks = 0;
    gpio_ports_a_b dut (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
        .wb_ack_o(ack), .portAIn(aIn), .portAOut(aOut), .portAOe(aOe), .portAPullup(aPu),
        .portBIn(bIn), .portBOut(bOut), .portBOe(bOe), .analog_channel_select(chan),
        .key_inputs(keyIn), .key_pin_enables(keyEn));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic finishTest();
        $display("checks=%0d mismatches=%0d", nChecks, nMismatch);
        if (nMismatch == 0 && nChecks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finishTest
    // values seen right after an edge are the ones that edge sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h1; datI <= {24'h00_0000, d};
        do @(posedge ref_clk); while (ack !== 1'b1);
        q = datO[7:0];
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge ref_clk);
    endtask : wb
    task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        `CHK(q, e)
    endtask : rdChk
    task automatic doReset();
        nrst <= 1'b0;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
    endtask : doReset
    ////////////////////////////////////////////////////////////////////////////
    task automatic resetValues();
        rdChk(ADDR_PORT_A_DIR, DIR_RESET);
        rdChk(ADDR_PORT_B_DIR, DIR_RESET);
        rdChk(ADDR_PORT_A_PULLUP, PULLUP_RESET);
        `CHK(aOe | bOe | aPu, 8'h00)
        rdChk(4'h2, 8'h00);
    endtask : resetValues
    task automatic portAMix();
        aIn <= 8'h3C;
        wb(1'b1, ADDR_PORT_A_DATA, 8'hA5);
        wb(1'b1, ADDR_PORT_A_DIR, 8'h0F);
        wb(1'b1, ADDR_PORT_A_PULLUP, 8'hFF);
        repeat (4) @(posedge ref_clk);
        rdChk(ADDR_PORT_A_DATA, 8'h35);
        rdChk(ADDR_PORT_A_DIR, 8'h0F);
        `CHK(aOe, 8'h0F)
        `CHK(aOut, 8'h05)
        `CHK(aPu, 8'hF0)
        wb(1'b1, ADDR_PORT_A_DATA, 8'h00);
        rdChk(ADDR_PORT_A_DATA, 8'h30);
        wb(1'b1, ADDR_PORT_A_PULLUP, 8'h0C);
        repeat (2) @(posedge ref_clk);
        `CHK(aPu, 8'h00)
        wb(1'b1, ADDR_PORT_A_DIR, 8'h00);
        repeat (2) @(posedge ref_clk);
        `CHK(aPu, 8'h0C)
        rdChk(ADDR_PORT_A_DATA, 8'h3C);
    endtask : portAMix
    task automatic keyPins();
        aIn <= 8'hC3;
        wb(1'b1, ADDR_KEY_ENABLE, 8'h85);
        repeat (5) @(posedge ref_clk);
        `CHK(keyEn, 8'h85)
        `CHK(keyIn, 8'h81)
    endtask : keyPins
    task automatic latchKeep();
        wb(1'b1, ADDR_PORT_A_DATA, 8'h6B);
        wb(1'b1, ADDR_PORT_B_DATA, 8'h5A);
        doReset();
        wb(1'b1, ADDR_PORT_A_DIR, 8'hFF);
        wb(1'b1, ADDR_PORT_B_DIR, 8'hF0);
        rdChk(ADDR_PORT_A_DATA, 8'h6B);
        rdChk(ADDR_PORT_B_DATA, 8'h5F);
    endtask : latchKeep
    task automatic portBAnalog();
        wb(1'b1, ADDR_PORT_B_DIR, 8'hFF);
        chan <= 5'h03;
        repeat (5) @(posedge ref_clk);
        `CHK(bOe, 8'hF7)
        `CHK(bOut, 8'h52)
        rdChk(ADDR_PORT_B_DATA, 8'h5A);
        chan <= CHAN_LIMIT;
        repeat (5) @(posedge ref_clk);
        `CHK(bOe, 8'hFF)
    endtask : portBAnalog
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = '0; datI = '0;
        aIn = 8'h00; bIn = 8'h0F; chan = CHAN_LIMIT;
        doReset();
        resetValues();
        portAMix();
        keyPins();
        latchKeep();
        portBAnalog();
        finishTest();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        nMismatch++;
        finishTest();
    end
endmodule : tb
`default_nettype wire
